// ==== nrn_pkg.sv ====
// Purpose: shared constants for the release-rate and noise-estimate bank
// Assumes: apb byte address = 4 * register index
// Notes:   index = {page bits, 6-bit base-relative offset}
package nrn_pkg;

    // ------------------------------------------------------------------
    // address map
    // ------------------------------------------------------------------
    localparam logic [1:0]  PAGE_RATE     = 2'h2;
    localparam logic [1:0]  PAGE_NOISE    = 2'h3;
    localparam logic [5:0]  OFS_RATE_A_LO = 6'h1C;
    localparam logic [5:0]  OFS_RATE_A_HI = 6'h1D;
    localparam logic [5:0]  OFS_RATE_B_LO = 6'h3C;
    localparam logic [5:0]  OFS_RATE_B_HI = 6'h3D;
    localparam logic [5:0]  OFS_NOIS_A_LO = 6'h02;
    localparam logic [5:0]  OFS_NOIS_A_HI = 6'h03;
    localparam logic [5:0]  OFS_NOIS_B_LO = 6'h22;
    localparam logic [5:0]  OFS_NOIS_B_HI = 6'h23;
    localparam int          IDX_LSB       = 2;
    localparam int          IDX_MSB       = 9;

    // ------------------------------------------------------------------
    // reset values, number format and channel count
    // ------------------------------------------------------------------
    localparam logic [7:0]  RATE_RST_HI   = 8'h41;
    localparam logic [7:0]  RATE_RST_LO   = 8'h00;
    localparam logic [15:0] NOISE_RST     = 16'h0000;
    localparam logic [15:0] GAIN_UNITY    = 16'h4000;
    localparam int          FRAC_BITS     = 14;
    localparam int          NUM_CH        = 2;

endpackage : nrn_pkg

// ==== nrn_gain_if.sv ====
// Purpose: carries one canceller's gain-ramp controls to its ramp core
// Assumes: single clock domain
// Notes:   ctl side is the register bank, core side owns the gain
`timescale 1ns/1ps
interface nrn_gain_if;
    logic        tick;
    logic        release_on;
    logic        load;
    logic [15:0] load_value;
    logic [15:0] rate;
    logic [15:0] gain;

    modport ctl  (output tick, output release_on, output load,
                  output load_value, output rate, input gain);
    modport core (input tick, input release_on, input load,
                  input load_value, input rate, output gain);
endinterface : nrn_gain_if

// ==== nrn_ramp.sv ====
// Purpose: residual suppressor gain that releases at the programmed rate
// Assumes: tick is a one-cycle pulse per sample period
// Notes:   gain is q2.14, unity = 4000 hex
`timescale 1ns/1ps
module nrn_ramp (
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // controls and gain
    nrn_gain_if.core  gif
);

    logic [15:0] gain_ff;
    logic [15:0] nxt_gain;
    logic [31:0] product;
    logic [17:0] scaled;
    logic        over;

    // ------------------------------------------------------------------
    // release step
    // ------------------------------------------------------------------
    // full 32-bit product so large rates cannot wrap before saturation
    assign product  = 32'(gain_ff) * 32'(gif.rate);
    assign scaled   = product[31:nrn_pkg::FRAC_BITS];
    assign over     = scaled > 18'(nrn_pkg::GAIN_UNITY);
    assign nxt_gain = gif.load ? gif.load_value :
                      (gif.tick && gif.release_on) ?
                      (over ? nrn_pkg::GAIN_UNITY : scaled[15:0]) :
                      gain_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gain_ff <= nrn_pkg::GAIN_UNITY;
        end else begin
            gain_ff <= nxt_gain;
        end
    end

    assign gif.gain = gain_ff;

endmodule : nrn_ramp

// ==== nrn_regs.sv ====
// Purpose: release-rate and noise-estimate registers of one canceller group
// Assumes: apb slave, one wait-free access phase, byte registers in bits 7:0
// Notes:   two cancellers share the bank; each drives its own ramp core
//          a 16-bit value is two independent bytes, so reading both
//          halves may straddle an estimate update
`timescale 1ns/1ps
module nrn_regs (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // sample timing and suppressor control
    input  wire logic                  sample_tick,
    input  wire logic [1:0]            release_req,
    input  wire logic [1:0]            gain_load,
    input  wire logic [1:0][15:0]      gain_load_value,
    // noise estimator
    input  wire logic [1:0]            noise_valid,
    input  wire logic [1:0][15:0]      noise_value,
    // suppressor gain
    output logic      [1:0][15:0]      suppressor_gain
);

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [7:0] idx,
                                 input logic [1:0] page,
                                 input logic [5:0] ofs);
        hit = (idx == {page, ofs});
    endfunction : hit

    logic [7:0]  idx;
    logic        addr_ok;
    logic        setup;
    logic        access;
    logic        hit_ra_lo;
    logic        hit_ra_hi;
    logic        hit_rb_lo;
    logic        hit_rb_hi;
    logic        hit_na_lo;
    logic        hit_na_hi;
    logic        hit_nb_lo;
    logic        hit_nb_hi;
    logic        hit_rate;
    logic        hit_noise;
    logic        bad;

    assign idx       = paddr[nrn_pkg::IDX_MSB:nrn_pkg::IDX_LSB];
    assign addr_ok   = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    assign setup     = psel && !penable;
    assign access    = psel && penable && pready;
    assign hit_ra_lo = addr_ok && hit(idx, nrn_pkg::PAGE_RATE,
                                      nrn_pkg::OFS_RATE_A_LO);
    assign hit_ra_hi = addr_ok && hit(idx, nrn_pkg::PAGE_RATE,
                                      nrn_pkg::OFS_RATE_A_HI);
    assign hit_rb_lo = addr_ok && hit(idx, nrn_pkg::PAGE_RATE,
                                      nrn_pkg::OFS_RATE_B_LO);
    assign hit_rb_hi = addr_ok && hit(idx, nrn_pkg::PAGE_RATE,
                                      nrn_pkg::OFS_RATE_B_HI);
    assign hit_na_lo = addr_ok && hit(idx, nrn_pkg::PAGE_NOISE,
                                      nrn_pkg::OFS_NOIS_A_LO);
    assign hit_na_hi = addr_ok && hit(idx, nrn_pkg::PAGE_NOISE,
                                      nrn_pkg::OFS_NOIS_A_HI);
    assign hit_nb_lo = addr_ok && hit(idx, nrn_pkg::PAGE_NOISE,
                                      nrn_pkg::OFS_NOIS_B_LO);
    assign hit_nb_hi = addr_ok && hit(idx, nrn_pkg::PAGE_NOISE,
                                      nrn_pkg::OFS_NOIS_B_HI);
    assign hit_rate  = hit_ra_lo || hit_ra_hi || hit_rb_lo || hit_rb_hi;
    assign hit_noise = hit_na_lo || hit_na_hi || hit_nb_lo || hit_nb_hi;
    // estimates are read-only; a write there is refused, not dropped silently
    assign bad       = !(hit_rate || hit_noise) || (pwrite && hit_noise);

    // ------------------------------------------------------------------
    // release-rate registers
    // ------------------------------------------------------------------
    logic [1:0][15:0] rate_ff;
    logic [1:0][15:0] nxt_rate;
    logic [1:0]       wr_lo;
    logic [1:0]       wr_hi;
    logic             wr_ok;

    assign wr_ok    = access && pwrite && !pslverr;
    assign wr_lo[0] = wr_ok && hit_ra_lo;
    assign wr_hi[0] = wr_ok && hit_ra_hi;
    assign wr_lo[1] = wr_ok && hit_rb_lo;
    assign wr_hi[1] = wr_ok && hit_rb_hi;

    // ------------------------------------------------------------------
    // noise estimates
    // ------------------------------------------------------------------
    logic [1:0][15:0] noise_ff;

    // ------------------------------------------------------------------
    // byte lanes
    // ------------------------------------------------------------------
    logic [1:0][7:0]  rate_lo_b;
    logic [1:0][7:0]  rate_hi_b;
    logic [1:0][7:0]  noise_lo_b;
    logic [1:0][7:0]  noise_hi_b;

    genvar ch;
    generate
        for (ch = 0; ch < nrn_pkg::NUM_CH; ch++) begin : g_ch
            nrn_gain_if gif ();

            // low byte sits at the even offset, high byte at the odd one
            assign rate_lo_b[ch]  = rate_ff[ch][7:0];
            assign rate_hi_b[ch]  = rate_ff[ch][15:8];
            assign noise_lo_b[ch] = noise_ff[ch][7:0];
            assign noise_hi_b[ch] = noise_ff[ch][15:8];

            // the bank stores any value; keeping it above unity is the
            // host's job, below unity the gain only ever decays
            assign nxt_rate[ch] = {wr_hi[ch] ? pwdata[7:0]
                                             : rate_ff[ch][15:8],
                                   wr_lo[ch] ? pwdata[7:0]
                                             : rate_ff[ch][7:0]};

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    rate_ff[ch] <= {nrn_pkg::RATE_RST_HI,
                                    nrn_pkg::RATE_RST_LO};
                end else begin
                    rate_ff[ch] <= nxt_rate[ch];
                end
            end

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    noise_ff[ch] <= nrn_pkg::NOISE_RST;
                end else if (noise_valid[ch]) begin
                    noise_ff[ch] <= noise_value[ch];
                end
            end

            assign gif.tick       = sample_tick;
            assign gif.release_on = release_req[ch];
            assign gif.load       = gain_load[ch];
            assign gif.load_value = gain_load_value[ch];
            assign gif.rate       = rate_ff[ch];

            nrn_ramp u_ramp (
                .clk    (clk),
                .arst_n (arst_n),
                .gif    (gif.core)
            );

            assign suppressor_gain[ch] = gif.gain;
        end
    endgenerate

    // ------------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------------
    logic [7:0]  rd_byte;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] nxt_prdata;
    logic        rd_setup;
    logic        err_setup;

    assign rd_byte = hit_ra_lo ? rate_lo_b[0]  :
                     hit_ra_hi ? rate_hi_b[0]  :
                     hit_rb_lo ? rate_lo_b[1]  :
                     hit_rb_hi ? rate_hi_b[1]  :
                     hit_na_lo ? noise_lo_b[0] :
                     hit_na_hi ? noise_hi_b[0] :
                     hit_nb_lo ? noise_lo_b[1] :
                     hit_nb_hi ? noise_hi_b[1] : 8'h00;
    assign rd_setup  = setup && !pwrite && !bad;
    assign err_setup = setup && bad;
    // read data is captured in setup, one cycle before the access edge
    assign nxt_prdata = rd_setup ? {24'h000000, rd_byte}
                                 : 32'h00000000;

    // every setup gets exactly one answer cycle, no wait states
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= setup;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pslverr_ff <= 1'b0;
        end else begin
            pslverr_ff <= err_setup;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_ff <= 32'h00000000;
        end else begin
            prdata_ff <= setup ? nxt_prdata : prdata_ff;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;

endmodule : nrn_regs

// ==== nrn_regs_props.sv ====
// Purpose: apb and gain checks on the nrn_regs ports
// Assumes: zero-wait apb slave, gain q2.14 with unity 4000 hex
// Notes:   bound into every nrn_regs instance
`timescale 1ns/1ps
module nrn_regs_props (
    // clock and reset
    input wire logic             clk,
    input wire logic             arst_n,
    // apb
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    // suppressor and estimator
    input wire logic             sample_tick,
    input wire logic [1:0]       release_req,
    input wire logic [1:0]       gain_load,
    input wire logic [1:0][15:0] gain_load_value,
    input wire logic [1:0]       noise_valid,
    input wire logic [1:0][15:0] noise_value,
    input wire logic [1:0][15:0] suppressor_gain
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence noise_wr_s;
        psel && !penable && pwrite && paddr[9:8] == 2'h3;
    endsequence
    sequence rate_s;
        psel && !penable && paddr[11:8] == 4'h2 && paddr[6:3] == 4'hE
            && paddr[1:0] == 2'h0;
    endsequence
    rdy_follow_a: assert property (setup_s |=> pready)
        else $error("no pready after setup");
    rdy_once_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    noise_ro_a: assert property (noise_wr_s ##1 pready |-> pslverr)
        else $error("noise write not refused");
    rate_ok_a: assert property (rate_s ##1 pready |-> !pslverr)
        else $error("rate access refused");
    unmapped_a: assert property (setup_s ##0 (!pwrite && paddr[9:8] == 2'h0)
        ##1 pready |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    gain_cap_a: assert property (sample_tick && release_req[0]
        && !gain_load[0] |=> suppressor_gain[0] <= 16'h4000)
        else $error("gain above unity");
    gain_rise_a: assert property (sample_tick && release_req[1]
        && !gain_load[1] && suppressor_gain[1] < 16'h4000
        |=> suppressor_gain[1] > $past(suppressor_gain[1]))
        else $error("gain did not rise on release");
    gain_hold_a: assert property (!sample_tick && !gain_load[0]
        |=> $stable(suppressor_gain[0]))
        else $error("gain moved without tick");
    gain_load_a: assert property (gain_load[1]
        |=> suppressor_gain[1] == $past(gain_load_value[1]))
        else $error("gain load lost");
endmodule : nrn_regs_props
bind nrn_regs nrn_regs_props u_nrn_regs_props (.clk, .arst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sample_tick, .release_req, .gain_load, .gain_load_value,
    .noise_valid, .noise_value, .suppressor_gain);

// ==== nrn_est_model.sv ====
// Purpose: sample timing and noise estimator feeding the bank
// Assumes: one clock, tick every PERIOD cycles
// Notes:   en low freezes the estimate so reads have a fixed answer
`timescale 1ns/1ps
module nrn_est_model #(
    parameter int PERIOD = 6
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // control
    input  wire logic             en,
    // estimator side
    output logic                  sample_tick,
    output logic [1:0]            noise_valid,
    output logic [1:0][15:0]      noise_value
);
    logic [7:0] cnt_ff;
    wire        upd = en && cnt_ff == 8'h03;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff      <= 8'h00;
            sample_tick <= 1'b0;
            noise_valid <= 2'h0;
            noise_value <= '0;
        end else begin
            cnt_ff      <= (cnt_ff == 8'(PERIOD - 1)) ? 8'h00 : cnt_ff + 8'h01;
            sample_tick <= cnt_ff == 8'h00;
            noise_valid <= {2{upd}};
            if (upd)
                noise_value <= {noise_value[0] ^ 16'hA5C3,
                                noise_value[1] + 16'h1357};
        end
    end
endmodule : nrn_est_model

// ==== nrn_release_and_noise_regs_tb_top.sv ====
// Purpose: self-checking bench for the release-rate and noise bank
// Assumes: apb byte address = 4 * index
// Notes:   reads are noted in a queue and checked by the monitor
`timescale 1ns/1ps
module nrn_release_and_noise_regs_tb_top;
    logic             clk = 1'b0, arst_n = 1'b0, en = 1'b0;
    logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]      paddr = 12'h000;
    logic [31:0]      pwdata = 32'h0, prdata;
    logic             pready, pslverr, tick;
    logic [1:0]       rel = 2'h0, ld = 2'h0, nvalid;
    logic [1:0][15:0] ldv = '0, nval, gain;
    logic [33:0]      exp_q[$], e;
    logic [7:0]       wv[8];
    logic [15:0]      ga, gb, rb;
    int               error_cnt = 0, n_checks = 0, cyc = 0, k;
    int               seed = 86645;
    localparam logic [11:0] AD[8] = '{12'h270, 12'h274, 12'h2F0, 12'h2F4,
                                      12'h308, 12'h30C, 12'h388, 12'h38C};
    always #12.5 clk = ~clk;

    nrn_regs u_nrn_regs (.clk, .arst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .sample_tick(tick),
        .release_req(rel), .gain_load(ld), .gain_load_value(ldv),
        .noise_valid(nvalid), .noise_value(nval), .suppressor_gain(gain));
    nrn_est_model u_nrn_est_model (.clk, .arst_n, .en, .sample_tick(tick),
        .noise_valid(nvalid), .noise_value(nval));

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // e = {write, error, data}; reads are checked whole, writes by error only
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d, input logic [8:0] x);
        exp_q.push_back({w, x[8], 24'h0, x[7:0]});
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'($random(seed)), d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [15:0] nxt(input logic [15:0] g, r);
        logic [31:0] p;
        p = ({16'h0, g} * {16'h0, r}) >> 14;
        return (p > 32'h4000) ? 16'h4000 : p[15:0];
    endfunction : nxt

    task automatic conclude;
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            e = exp_q.pop_front();
            chk({pslverr, e[33] ? e[31:0] : prdata}, e[32:0]);
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            conclude();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        chk({17'h0, gain[0]}, {17'h0, 16'h4000});
        chk({17'h0, gain[1]}, {17'h0, 16'h4000});
        for (int i = 0; i < 8; i++)
            apb(0, AD[i], 0, (i < 4 && i % 2) ? 9'h041 : 9'h000);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            wv[i] = 8'($random(seed));
            if (i % 2)
                wv[i] = 8'h41 + {3'h0, wv[i][4:0]};
            apb(1, AD[i], wv[i], {i > 3, 8'h00});
        end
        for (int i = 0; i < 8; i++)
            apb(0, AD[i], 0, {1'b0, i > 3 ? 8'h00 : wv[i]});
        apb(1, 12'h000, 8'h55, 9'h100);
        apb(0, 12'h004, 0, 9'h100);
        apb(0, 12'h271, 0, 9'h100);
        $display("test access done");
        en <= 1'b1;
        repeat (20) @(posedge clk);
        en <= 1'b0;
        repeat (10) @(posedge clk);
        for (int i = 4; i < 8; i++)
            apb(0, AD[i], 0, {1'b0, nval[i > 5][(i % 2) * 8 +: 8]});
        $display("test noise done");
        apb(1, 12'h270, 8'h00, 9'h000);
        apb(1, 12'h274, 8'h41, 9'h000);
        apb(1, 12'h2F4, 8'h60, 9'h000);
        rb = {8'h60, wv[2]};
        @(posedge clk);
        ldv <= {16'h1000, 16'h1000};
        ld  <= 2'h3;
        @(posedge clk);
        ld  <= 2'h0;
        rel <= 2'h3;
        k = 0;
        while (k < 6) begin
            @(negedge clk);
            k += int'(tick);
        end
        @(posedge clk);
        rel <= 2'h0;
        @(negedge clk);
        ga = 16'h1000;
        gb = 16'h1000;
        repeat (6) begin
            ga = nxt(ga, 16'h4100);
            gb = nxt(gb, rb);
        end
        chk({17'h0, gain[0]}, {17'h0, ga});
        chk({17'h0, gain[1]}, {17'h0, gb});
        chk({32'h0, gain[1] > gain[0]}, 33'h1);
        $display("test release done");
        @(posedge clk);
        arst_n <= 1'b0;
        @(posedge clk);
        chk({17'h0, gain[0]}, {17'h0, 16'h4000});
        arst_n <= 1'b1;
        apb(0, AD[3], 0, 9'h041);
        apb(0, AD[2], 0, 9'h000);
        apb(0, AD[4], 0, 9'h000);
        $display("test mid-run reset done");
        conclude();
    end
endmodule : nrn_release_and_noise_regs_tb_top
